//--- rtl/pbwc_pkg.sv
// constants and types shared by the power button and wake controller
`default_nettype none

package pbwc_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ        = 200_000_000;

  // switch hold thresholds, in seconds
  localparam int unsigned SW_SHORT_SEC  = 4;
  localparam int unsigned SW_LONG_SEC   = 6;

  // switch debounce time, in milliseconds
  localparam int unsigned DEBOUNCE_MS   = 10;

  // derived cycle counts
  localparam int unsigned SW_SHORT_CYC  = SW_SHORT_SEC * CLK_HZ;
  localparam int unsigned SW_LONG_CYC   = SW_LONG_SEC * CLK_HZ;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);

  // counter widths
  localparam int          HOLD_W        = 31;
  localparam int          DB_W          = 22;

  // pin vector layout (bit index of each sampled pin)
  localparam int          PIN_NUM       = 6;
  localparam int          PIN_SW        = 0;
  localparam int          PIN_PME       = 1;
  localparam int          PIN_PCIE      = 2;
  localparam int          PIN_LAN       = 3;
  localparam int          PIN_RTC       = 4;
  localparam int          PIN_USB       = 5;

  // pins that are active low (switch, pme, pcie wake)
  localparam logic [5:0]  PIN_ACT_LOW   = 6'h07;

  // sleeping state codes
  typedef enum logic [2:0] {
    ST_S0 = 3'h0,
    ST_S1 = 3'h1,
    ST_S3 = 3'h3,
    ST_S4 = 3'h4,
    ST_S5 = 3'h5
  } pbwc_state_e;

  // global state codes
  localparam logic [1:0]  G_WORK        = 2'h0;
  localparam logic [1:0]  G_SLEEP       = 2'h1;
  localparam logic [1:0]  G_OFF         = 2'h2;

  // state entered on reset and on a short press while working
  localparam pbwc_state_e RESET_STATE   = ST_S5;
  localparam pbwc_state_e SW_SLEEP_ST   = ST_S3;

  // reset value of the s5 wake option for lan and pme
  localparam logic        S5_EN_RST     = 1'h0;

endpackage : pbwc_pkg

`default_nettype wire

//--- rtl/pbwc_debounce.sv
// debounce filter for the front-panel power switch
`default_nettype none

module pbwc_debounce
  import pbwc_pkg::*;
#(
  parameter int unsigned P_DB_CYC = DEBOUNCE_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  input  wire logic i_level,
  output logic      o_level
);

  logic            level_ff;
  logic            nxt_level;
  logic [DB_W-1:0] cnt_ff;
  logic [DB_W-1:0] nxt_cnt;

  // accept a new level only once it has stood for the full debounce time
  always_comb begin
    nxt_level = level_ff;
    nxt_cnt   = cnt_ff;
    if (i_level == level_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= DB_W'(P_DB_CYC - 1)) begin
      nxt_level = i_level;
      nxt_cnt   = '0;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // filter registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      level_ff <= 1'b0;
      cnt_ff   <= '0;
    end else begin
      level_ff <= nxt_level;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign o_level = level_ff;

endmodule : pbwc_debounce

`default_nettype wire

//--- rtl/pbwc_top.sv
// power button and wake source controller for the global power state
// Summary of operation
// [RULE_01] The hold time of the power switch is measured and, with the current state, picks the next state.
// [RULE_02] From soft-off, a press released under four seconds moves the system to working.
// [RULE_03] From working, a press released under four seconds moves the system to sleeping.
// [RULE_04] From working, a hold beyond six seconds forces soft-off at once without software.
// [RULE_05] From sleeping, a press released under four seconds wakes the system to working.
// [RULE_06] From sleeping, a hold beyond six seconds moves the system to soft-off.
// [RULE_07] The switch is debounced, and a hold between four and six seconds changes nothing.
// [RULE_08] Other state changes happen only when the operating system commands them.
// [RULE_09] Switch, alarm and express wake work from S1 to S5; usb wakes only from S1 and S3.
// [RULE_10] Lan and pme wake from S1, S3 and S4, and from S5 only with the S5 option set.
// [RULE_11] After reset the S5 wake option for lan and pme is held cleared.
// [RULE_12] Firmware sets the S5 option when lan is to wake the system from S5.
// [RULE_13] In S4 the processor is unpowered while the wake logic stays powered.
// [RULE_14] An express wake assertion wakes the system from S1 to S5 with no enable.
`default_nettype none

module pbwc_top
  import pbwc_pkg::*;
#(
  parameter int unsigned P_SHORT_CYC = SW_SHORT_CYC,
  parameter int unsigned P_LONG_CYC  = SW_LONG_CYC,
  parameter int unsigned P_DB_CYC    = DEBOUNCE_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_pwr_sw_n,
  input  wire logic       i_pme_n,
  input  wire logic       i_pcie_wake_n,
  input  wire logic       i_lan_wake,
  input  wire logic       i_rtc_alarm,
  input  wire logic       i_usb_wake,
  input  wire logic       i_s5_wake_en,
  input  wire logic       i_os_cmd_valid,
  input  wire logic [2:0] i_os_cmd_state,
  output logic      [2:0] o_sleep_state,
  output logic      [1:0] o_global_state,
  output logic            o_cpu_pwr_en,
  output logic            o_wake_pwr_en,
  output logic            o_wake_pulse,
  output logic      [5:0] o_wake_src,
  output logic            o_fail_safe_pulse,
  output logic            o_cmd_reject_pulse
);

  // global state of a sleeping state code
  function automatic logic [1:0] glob_of(input pbwc_state_e st);
    return (st == ST_S0) ? G_WORK : (st == ST_S5) ? G_OFF : G_SLEEP;
  endfunction : glob_of

  // pin synchronisers
  logic [PIN_NUM-1:0] pin_raw;
  logic [PIN_NUM-1:0] sync1_ff;
  logic [PIN_NUM-1:0] sync2_ff;
  logic [PIN_NUM-1:0] pin_act;
  logic [PIN_NUM-1:0] act_prev_ff;
  logic [PIN_NUM-1:0] wake_edge;

  // switch tracking
  logic               sw_level;
  logic               sw_prev_ff;
  logic               sw_release;
  logic [HOLD_W-1:0]  hold_ff;
  logic [HOLD_W-1:0]  nxt_hold;
  logic               done_ff;
  logic               nxt_done;
  logic               long_hit;
  logic               rel_short;

  // power state
  pbwc_state_e        state_ff;
  pbwc_state_e        nxt_state;
  logic               s5_en_ff;
  logic               wake_ok;
  logic [5:0]         wake_en;
  logic               cmd_legal;
  logic               wake_pulse_ff;
  logic               nxt_wake_pulse;
  logic [5:0]         wake_src_ff;
  logic [5:0]         nxt_wake_src;
  logic               fs_pulse_ff;
  logic               nxt_fs_pulse;
  logic               rej_ff;
  logic               nxt_rej;
  logic               cpu_pwr_ff;
  logic               wake_pwr_ff;
  logic [1:0]         glob_ff;

  assign pin_raw = {i_usb_wake, i_rtc_alarm, i_lan_wake,
                    i_pcie_wake_n, i_pme_n, i_pwr_sw_n};

  // two flops on every pin before any logic looks at it
  for (genvar gi = 0; gi < PIN_NUM; gi++) begin : g_sync
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
        sync1_ff[gi] <= PIN_ACT_LOW[gi];
        sync2_ff[gi] <= PIN_ACT_LOW[gi];
      end else begin
        sync1_ff[gi] <= pin_raw[gi];
        sync2_ff[gi] <= sync1_ff[gi];
      end
    end
  end

  // asserted levels and rising edges of the wake pins
  assign pin_act   = sync2_ff ^ PIN_ACT_LOW;
  assign wake_edge = pin_act & ~act_prev_ff;

  // switch debounce
  pbwc_debounce #(
    .P_DB_CYC (P_DB_CYC)
  ) u_debounce (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_level   (pin_act[PIN_SW]), // RULE_07
    .o_level   (sw_level)
  );

  // hold length decisions
  assign sw_release = sw_prev_ff && !sw_level;
  assign rel_short  = sw_release && !done_ff &&
                      (hold_ff < HOLD_W'(P_SHORT_CYC)); // RULE_01
  assign long_hit   = sw_level && !done_ff &&
                      (hold_ff == HOLD_W'(P_LONG_CYC)); // RULE_01

  // hold counter, saturates at the long threshold
  always_comb begin
    nxt_hold = hold_ff;
    nxt_done = done_ff;
    if (!sw_level) begin
      nxt_hold = '0;
      nxt_done = 1'b0;
    end else if (hold_ff < HOLD_W'(P_LONG_CYC)) begin
      nxt_hold = hold_ff + 1'b1; // RULE_01
    end else begin
      nxt_done = 1'b1;
    end
  end

  // wake sources allowed in the present state
  always_comb begin
    wake_en = '0;
    case (state_ff)
      ST_S1, ST_S3: wake_en = 6'h3E; // RULE_09
      ST_S4:        wake_en = 6'h1E; // RULE_13
      ST_S5: begin
        wake_en[PIN_PCIE] = 1'b1; // RULE_14
        wake_en[PIN_RTC]  = 1'b1; // RULE_09
        wake_en[PIN_LAN]  = s5_en_ff; // RULE_10
        wake_en[PIN_PME]  = s5_en_ff; // RULE_10
      end
      default:      wake_en = '0;
    endcase
  end

  assign wake_ok = |(wake_edge & wake_en);

  // legal command codes from software
  always_comb begin
    case (i_os_cmd_state)
      ST_S0, ST_S1, ST_S3, ST_S4, ST_S5: cmd_legal = 1'b1;
      default:                           cmd_legal = 1'b0;
    endcase
  end

  // next power state: switch first, then wake, then software
  always_comb begin
    nxt_state      = state_ff;
    nxt_wake_pulse = 1'b0;
    nxt_wake_src   = wake_src_ff;
    nxt_fs_pulse   = 1'b0;
    nxt_rej        = 1'b0;
    if (long_hit && glob_of(state_ff) == G_WORK) begin
      nxt_state    = ST_S5; // RULE_04
      nxt_fs_pulse = 1'b1;
    end else if (long_hit && glob_of(state_ff) == G_SLEEP) begin
      nxt_state = ST_S5; // RULE_06
    end else if (rel_short && glob_of(state_ff) == G_OFF) begin
      nxt_state      = ST_S0; // RULE_02
      nxt_wake_pulse = 1'b1;
      nxt_wake_src   = 6'h01;
    end else if (rel_short && glob_of(state_ff) == G_WORK) begin
      nxt_state = SW_SLEEP_ST; // RULE_03
    end else if (rel_short && glob_of(state_ff) == G_SLEEP) begin
      nxt_state      = ST_S0; // RULE_05
      nxt_wake_pulse = 1'b1;
      nxt_wake_src   = 6'h01;
    end else if (wake_ok) begin
      nxt_state      = ST_S0; // RULE_09
      nxt_wake_pulse = 1'b1;
      nxt_wake_src   = wake_edge & wake_en;
    end else if (i_os_cmd_valid && cmd_legal) begin
      nxt_state = pbwc_state_e'(i_os_cmd_state); // RULE_08
    end else if (i_os_cmd_valid) begin
      nxt_rej = 1'b1;
    end
  end

  // state and status registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff      <= RESET_STATE;
      glob_ff       <= G_OFF; // soft-off at reset
      act_prev_ff   <= '0;
      sw_prev_ff    <= 1'b0;
      hold_ff       <= '0;
      done_ff       <= 1'b0;
      s5_en_ff      <= S5_EN_RST; // RULE_11
      wake_pulse_ff <= 1'b0;
      wake_src_ff   <= '0;
      fs_pulse_ff   <= 1'b0;
      rej_ff        <= 1'b0;
      cpu_pwr_ff    <= 1'b0;
      wake_pwr_ff   <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      glob_ff       <= glob_of(nxt_state);
      act_prev_ff   <= pin_act;
      sw_prev_ff    <= sw_level;
      hold_ff       <= nxt_hold;
      done_ff       <= nxt_done;
      s5_en_ff      <= i_s5_wake_en; // RULE_12
      wake_pulse_ff <= nxt_wake_pulse;
      wake_src_ff   <= nxt_wake_src;
      fs_pulse_ff   <= nxt_fs_pulse;
      rej_ff        <= nxt_rej;
      cpu_pwr_ff    <= (nxt_state == ST_S0) || (nxt_state == ST_S1); // RULE_13
      wake_pwr_ff   <= 1'b1; // RULE_13
    end
  end

  // outputs straight from flops
  assign o_sleep_state      = state_ff;
  assign o_global_state     = glob_ff;
  assign o_cpu_pwr_en       = cpu_pwr_ff;
  assign o_wake_pwr_en      = wake_pwr_ff;
  assign o_wake_pulse       = wake_pulse_ff;
  assign o_wake_src         = wake_src_ff;
  assign o_fail_safe_pulse  = fs_pulse_ff;
  assign o_cmd_reject_pulse = rej_ff;

  // checks on the state transitions, the s5 option after reset and the S4 power enables
  property p_long_from_work;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (state_ff == ST_S0 && long_hit) |=> (state_ff == ST_S5) && fs_pulse_ff;
  endproperty
  a_long_from_work: assert property (p_long_from_work) // RULE_04
    else $error("long hold in working did not force soft-off");

  property p_short_from_off;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (state_ff == ST_S5 && rel_short) |=> state_ff == ST_S0 && wake_pulse_ff;
  endproperty
  a_short_from_off: assert property (p_short_from_off) // RULE_02
    else $error("short press in soft-off did not power on");

  property p_short_from_work;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (state_ff == ST_S0 && rel_short) |=> (state_ff == SW_SLEEP_ST);
  endproperty
  a_short_from_work: assert property (p_short_from_work) // RULE_03
    else $error("short press in working did not enter sleep");

  property p_short_from_sleep;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (glob_of(state_ff) == G_SLEEP && rel_short) |=> (state_ff == ST_S0);
  endproperty
  a_short_from_sleep: assert property (p_short_from_sleep) // RULE_05
    else $error("short press in sleep did not wake");

  property p_long_from_sleep;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (glob_of(state_ff) == G_SLEEP && long_hit) |=> (state_ff == ST_S5);
  endproperty
  a_long_from_sleep: assert property (p_long_from_sleep) // RULE_06
    else $error("long hold in sleep did not enter soft-off");

  property p_mid_hold;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (sw_release && hold_ff >= HOLD_W'(P_SHORT_CYC) && !wake_ok &&
     !i_os_cmd_valid) |=> $stable(state_ff);
  endproperty
  a_mid_hold: assert property (p_mid_hold) // RULE_07
    else $error("mid-length hold changed the power state");

  property p_change_cause;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    ##1 (state_ff != $past(state_ff)) |->
      $past(long_hit || rel_short || wake_ok ||
            (i_os_cmd_valid && cmd_legal));
  endproperty
  a_change_cause: assert property (p_change_cause) // RULE_08
    else $error("power state changed with no cause");

  property p_usb_deep;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    ((state_ff == ST_S4 || state_ff == ST_S5) &&
     wake_edge == 6'h20 && !long_hit && !rel_short && !i_os_cmd_valid)
      |=> $stable(state_ff) && !wake_pulse_ff;
  endproperty
  a_usb_deep: assert property (p_usb_deep) // RULE_09
    else $error("usb woke the system from S4 or S5");

  property p_s5_option;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (state_ff == ST_S5 && !s5_en_ff && (wake_edge & 6'h14) == 6'h00 &&
     !long_hit && !rel_short && !i_os_cmd_valid) |=> (state_ff == ST_S5);
  endproperty
  a_s5_option: assert property (p_s5_option) // RULE_10
    else $error("lan or pme woke S5 without the option");

  property p_s5_reset;
    @(posedge i_clk_sys)
    $rose(i_resetn) |-> !s5_en_ff;
  endproperty
  a_s5_reset: assert property (p_s5_reset) // RULE_11
    else $error("S5 option not cleared after reset");

  property p_deep_power;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    ##1 (state_ff == ST_S4) |-> !o_cpu_pwr_en && o_wake_pwr_en;
  endproperty
  a_deep_power: assert property (p_deep_power) // RULE_13
    else $error("S4 power rails wrong");

  property p_pcie_wake;
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (state_ff != ST_S0 && wake_edge[PIN_PCIE] && !long_hit && !rel_short)
      |=> (state_ff == ST_S0) && wake_pulse_ff && wake_src_ff[PIN_PCIE];
  endproperty
  a_pcie_wake: assert property (p_pcie_wake) // RULE_14
    else $error("express wake did not wake the system");

endmodule : pbwc_top

`default_nettype wire

//--- test/pbwc_src_model.sv
// stand-in for the front-panel switch and the external wake sources
`default_nettype none

module pbwc_src_model
  import pbwc_pkg::*;
(
  input  wire logic i_clk_sys,
  output logic      o_pwr_sw_n,
  output logic      o_pme_n,
  output logic      o_pcie_wake_n,
  output logic      o_lan_wake,
  output logic      o_rtc_alarm,
  output logic      o_usb_wake
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [PIN_NUM-1:0] act_lvl;

  // asserted levels mapped to pin polarity; an idle pin rests deasserted
  assign o_pwr_sw_n    = act_lvl[PIN_SW] ^ PIN_ACT_LOW[PIN_SW];
  assign o_pme_n       = act_lvl[PIN_PME] ^ PIN_ACT_LOW[PIN_PME];
  assign o_pcie_wake_n = act_lvl[PIN_PCIE] ^ PIN_ACT_LOW[PIN_PCIE];
  assign o_lan_wake    = act_lvl[PIN_LAN] ^ PIN_ACT_LOW[PIN_LAN];
  assign o_rtc_alarm   = act_lvl[PIN_RTC] ^ PIN_ACT_LOW[PIN_RTC];
  assign o_usb_wake    = act_lvl[PIN_USB] ^ PIN_ACT_LOW[PIN_USB];

  initial begin
    act_lvl = '0;
  end

  // hold one pin asserted for a count of cycles, then let it go
  task automatic hold_pin(input int idx, input int cyc);
    @(posedge i_clk_sys);
    #1;
    act_lvl[idx] = 1'b1;
    repeat (cyc) @(posedge i_clk_sys);
    #1;
    act_lvl[idx] = 1'b0;
  endtask : hold_pin

endmodule : pbwc_src_model

`default_nettype wire

//--- test/pbwc_top_bench.sv
// self-checking bench for the power button and wake controller
`default_nettype none

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  err_total++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module pbwc_top_bench
  import pbwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_clk_sys, i_resetn, i_s5_wake_en, i_os_cmd_valid;
  logic [2:0] i_os_cmd_state;
  wire logic  sw_n, pme_n, pcie_n, lan, rtc, usb;
  logic [2:0] o_sleep_state;
  logic [1:0] o_global_state;
  logic       o_cpu_pwr_en, o_wake_pwr_en, o_wake_pulse;
  logic [5:0] o_wake_src;
  logic       o_fail_safe_pulse, o_cmd_reject_pulse;
  int         err_total, checks_done, cyc_cnt;
  int         n_wake, n_fail, n_rej, e_wake;
  logic [5:0] e_src;

  pbwc_top #(.P_SHORT_CYC(40), .P_LONG_CYC(60), .P_DB_CYC(4)) i_pbwc_top (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_pwr_sw_n(sw_n),
    .i_pme_n(pme_n), .i_pcie_wake_n(pcie_n), .i_lan_wake(lan),
    .i_rtc_alarm(rtc), .i_usb_wake(usb), .i_s5_wake_en(i_s5_wake_en),
    .i_os_cmd_valid(i_os_cmd_valid), .i_os_cmd_state(i_os_cmd_state),
    .o_sleep_state(o_sleep_state), .o_global_state(o_global_state),
    .o_cpu_pwr_en(o_cpu_pwr_en), .o_wake_pwr_en(o_wake_pwr_en),
    .o_wake_pulse(o_wake_pulse), .o_wake_src(o_wake_src),
    .o_fail_safe_pulse(o_fail_safe_pulse),
    .o_cmd_reject_pulse(o_cmd_reject_pulse));

  pbwc_src_model i_pbwc_src_model (
    .i_clk_sys(i_clk_sys), .o_pwr_sw_n(sw_n), .o_pme_n(pme_n),
    .o_pcie_wake_n(pcie_n), .o_lan_wake(lan), .o_rtc_alarm(rtc),
    .o_usb_wake(usb));

  // 200 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  // pulse counters and the hang guard
  always @(posedge i_clk_sys) begin
    cyc_cnt++;
    if (o_wake_pulse === 1'b1) n_wake++;
    if (o_fail_safe_pulse === 1'b1) n_fail++;
    if (o_cmd_reject_pulse === 1'b1) n_rej++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // wake permission per state, source and s5 option
  function automatic logic allow(input int st, input int idx, input logic op);
    case (st)
      1, 3:    return 1'b1;
      4:       return idx != PIN_USB;
      5:       return idx == PIN_PCIE || idx == PIN_RTC ||
                      ((idx == PIN_PME || idx == PIN_LAN) && op);
      default: return 1'b0;
    endcase
  endfunction : allow

  // compare state, global state and power enables
  task automatic chk_st(input logic [2:0] st);
    logic [1:0] g;
    #1; // let the edge's updates and pulse counts settle
    g = (st == 3'h0) ? G_WORK : (st == 3'h5) ? G_OFF : G_SLEEP;
    `CHK("state", st, o_sleep_state)
    `CHK("global", g, o_global_state)
    `CHK("cpu_pwr", (st <= 3'h1), o_cpu_pwr_en)
    `CHK("wake_pwr", 1'b1, o_wake_pwr_en)
    `CHK("wake_cnt", e_wake, n_wake)
    `CHK("wake_src", e_src, o_wake_src)
  endtask : chk_st

  // one software command pulse, then let it land
  task automatic os_cmd(input logic [2:0] code);
    @(posedge i_clk_sys);
    #1;
    i_os_cmd_valid = 1'b1;
    i_os_cmd_state = code;
    @(posedge i_clk_sys);
    #1;
    i_os_cmd_valid = 1'b0;
    @(posedge i_clk_sys);
  endtask : os_cmd

  // press and release the switch, then wait out sync and debounce
  task automatic press(input int cyc);
    i_pbwc_src_model.hold_pin(PIN_SW, cyc);
    repeat (12) @(posedge i_clk_sys);
  endtask : press

  task automatic t_reset;
    chk_st(3'h5);
    `CHK("fail_cnt", 0, n_fail)
  endtask : t_reset

  task automatic t_switch;
    press(2);
    chk_st(3'h5);
    press(20);
    e_wake++;
    e_src = 6'h01;
    chk_st(3'h0);
    press(20);
    chk_st(SW_SLEEP_ST);
    press(20);
    e_wake++;
    chk_st(3'h0);
    press(50);
    chk_st(3'h0);
    press(80);
    chk_st(3'h5);
    `CHK("fail_cnt", 1, n_fail)
    os_cmd(3'h3);
    press(80);
    chk_st(3'h5);
    `CHK("fail_cnt", 1, n_fail)
    press(50);
    chk_st(3'h5);
  endtask : t_switch

  task automatic t_os;
    os_cmd(3'h1);
    chk_st(3'h1);
    os_cmd(3'h4);
    chk_st(3'h4);
    os_cmd(3'h2);
    chk_st(3'h4);
    `CHK("rej_cnt", 1, n_rej)
    os_cmd(3'h0);
    chk_st(3'h0);
  endtask : t_os

  task automatic t_wake;
    int sts [5] = '{0, 1, 3, 4, 5};
    for (int op = 0; op < 2; op++) begin
      @(posedge i_clk_sys);
      #1;
      i_s5_wake_en = op[0];
      foreach (sts[k]) begin
        for (int idx = PIN_PME; idx <= PIN_USB; idx++) begin
          os_cmd(sts[k][2:0]);
          i_pbwc_src_model.hold_pin(idx, 6);
          repeat (4) @(posedge i_clk_sys);
          if (allow(sts[k], idx, op[0])) begin
            e_wake++;
            e_src = 6'h01 << idx;
            chk_st(3'h0);
          end else begin
            chk_st(sts[k][2:0]);
          end
        end
      end
    end
  endtask : t_wake

  // counts, verdict and stop
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    err_total = 0;
    checks_done = 0;
    cyc_cnt = 0;
    n_wake = 0;
    n_fail = 0;
    n_rej = 0;
    e_wake = 0;
    e_src = 6'h00;
    i_resetn = 1'b0;
    i_s5_wake_en = 1'b0;
    i_os_cmd_valid = 1'b0;
    i_os_cmd_state = 3'h0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_resetn = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t_reset();
    t_switch();
    t_os();
    t_wake();
    end_of_test();
  end

endmodule : pbwc_top_bench

`default_nettype wire
